// ===== hdl/main_clock_controller.sv
// main clock controller: source selection, prescaler, oscillator requests, protected config
// assumes oscillator ready/edge inputs are synchronous to clk_sys; clock outputs are enables
// How it works
// - internal sources start automatically on any peripheral request that needs them
// - each peripheral request is routed to its own needed source
// - main clock passes a prescaler with 12 settings from 1x to 64x
// - cpu clock and peripheral clock are derived from the main clock
// - rtc clock requested when counter or periodic timer is enabled
// - watchdog clock on when enabled; brown-out clock only in sampled mode
// - main source chosen by the main source select field
// - sources neither used nor requested are powered off
// - run-in-standby keeps an oscillator on except in power-down
// - run-in-standby makes a peripheral request ready at once
// - main clock runs in active/idle; in standby only if requested or run-in-standby is set for its active source
// - power-down stops main clock only after nvm operations finish
// - switch to external source only after enough detected edges
// - while waiting for external edges, further source changes are refused
// - switch pending flag is one during a source change
// - external clock stable flag reports external source stability
// - one status bit per oscillator shows running and stable
// - no recovery from a failed external source except system reset
// - after reset: fast internal oscillator, prescaler factor 6
// - select and prescaler accept writes only via timed protection
// - protected write valid only within four instructions of key
// - unprotected writes leave protected registers unchanged
// - external input usable two cycles after first request, pin configured
`timescale 1ns/1ps
`default_nettype none
module main_clock_controller
  import clock_controller_pkg::*;
#(
  parameter int EDGES_NEEDED = EXT_EDGES
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire sleep_mode_t        sleep_mode,
  input  wire periph_req_t        periph_req,
  input  wire logic               nvm_busy,
  input  wire logic               key_write,
  input  wire logic               instr_retire,
  input  wire logic               wr_select,
  input  wire logic [1:0]         wdata_select,
  input  wire logic               wr_prescaler,
  input  wire logic [PDIV_W-1:0]  wdata_pdiv,
  input  wire logic               wdata_pen,
  input  wire logic               wr_standby,
  input  wire logic               wdata_fast_standby,
  input  wire logic               wdata_slow_standby,
  input  wire logic               fast_ready,
  input  wire logic               slow_ready,
  input  wire logic               ext_edge,
  output logic                    fast_enable,
  output logic                    slow_enable,
  output logic                    ext_pin_is_clock,
  output logic                    rtc_clock_req,
  output logic                    watchdog_domain_clock,
  output logic                    brownout_domain_clock,
  output logic                    main_clock_run,
  output logic                    cpu_clock_en,
  output logic                    peripheral_clock_pin_out,
  output logic [1:0]              main_source_select,
  output logic [PDIV_W-1:0]       prescaler_div,
  output logic                    prescaler_en,
  output main_clock_status_t      main_clock_status_reg
);
  logic [1:0]       active_src;
  logic [1:0]       unlock_cnt;
  logic [CNT_W-1:0] edge_cnt;
  logic [1:0]       ext_age;
  logic             fast_standby;
  logic             slow_standby;
  logic [6:0]       div_cnt;
  logic             cpu_tick;

  // timed protection window
  wire unlocked      = unlock_cnt != 2'h0;
  wire ext_waiting   = main_source_select == SRC_EXT && active_src != SRC_EXT;
  wire sel_accept    = wr_select && unlocked && !ext_waiting;
  wire pre_accept    = wr_prescaler && unlocked;
  wire sby_accept    = wr_standby && unlocked;

  // request routing per source
  wire slow_req      = periph_req.rtc_en || periph_req.pit_en || periph_req.wdt_en
                       || periph_req.bod_sampled;
  wire powerdown     = sleep_mode == MODE_POWERDOWN;
  wire main_wanted   = (sleep_mode == MODE_ACTIVE) || (sleep_mode == MODE_IDLE)
                       || (sleep_mode == MODE_STANDBY && (periph_req.main_req
                       || (active_src == SRC_FAST && fast_standby)
                       || (active_src == SRC_SLOW && slow_standby)))
                       || (powerdown && nvm_busy);
  wire main_uses_fast = main_wanted && (active_src == SRC_FAST || main_source_select == SRC_FAST);
  wire main_uses_slow = main_wanted && (active_src == SRC_SLOW || main_source_select == SRC_SLOW);
  wire main_uses_ext  = main_wanted && (active_src == SRC_EXT || main_source_select == SRC_EXT);
  wire next_fast_en  = main_uses_fast || (fast_standby && !powerdown);
  wire next_slow_en  = main_uses_slow || slow_req || (slow_standby && !powerdown);
  wire ext_wanted    = main_uses_ext || periph_req.ext_req;
  wire ext_usable    = ext_age == 2'(EXT_START_CYC);
  wire ext_stable    = ext_usable && edge_cnt >= CNT_W'(EDGES_NEEDED);
  wire fast_ok       = fast_enable && fast_ready;
  wire slow_ok       = slow_enable && slow_ready;
  wire target_ok     = (main_source_select == SRC_FAST && fast_ok)
                       || (main_source_select == SRC_SLOW && slow_ok)
                       || (main_source_select == SRC_EXT && ext_stable);
  // a dead external source simply leaves the main clock stalled
  wire active_ok     = (active_src == SRC_FAST) ? fast_ok :
                       (active_src == SRC_SLOW) ? slow_ok : ext_edge;
  wire [6:0] factor  = pdiv_factor(prescaler_div);
  wire div_legal     = factor != 7'h00;
  wire div_wrap      = !prescaler_en || !div_legal || div_cnt >= factor - 7'h01;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      unlock_cnt <= 2'h0;
    end else if (key_write) begin
      unlock_cnt <= 2'(UNLOCK_INSTR - 1);
    end else if (wr_select || wr_prescaler || wr_standby) begin
      unlock_cnt <= 2'h0;
    end else if (instr_retire && unlocked) begin
      unlock_cnt <= unlock_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_source_select <= RESET_SRC;
      prescaler_div      <= RESET_PDIV;
      prescaler_en       <= RESET_PEN;
      fast_standby       <= 1'b0;
      slow_standby       <= 1'b0;
    end else begin
      if (sel_accept)
        main_source_select <= wdata_select;
      if (pre_accept) begin
        prescaler_div <= wdata_pdiv;
        prescaler_en  <= wdata_pen;
      end
      if (sby_accept) begin
        fast_standby <= wdata_fast_standby;
        slow_standby <= wdata_slow_standby;
      end
    end
  end

  // handover happens only once the new source is proven; old source keeps clocking meanwhile
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_src <= RESET_SRC;
    end else if (active_src != main_source_select && target_ok) begin
      active_src <= main_source_select;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_age  <= 2'h0;
      edge_cnt <= '0;
    end else if (!ext_wanted) begin
      ext_age  <= 2'h0;
      edge_cnt <= '0;
    end else begin
      if (!ext_usable)
        ext_age <= ext_age + 2'h1;
      if (ext_usable && ext_edge && !ext_stable)
        edge_cnt <= edge_cnt + CNT_W'(1);
    end
  end

  // prescaler counts only while main clock ticks, so the divided clock never has short pulses
  wire main_tick = main_wanted && active_ok;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 7'h00;
    end else if (main_tick) begin
      div_cnt <= div_wrap ? 7'h00 : div_cnt + 7'h01;
    end
  end

  assign cpu_tick = main_tick;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_enable              <= 1'b1;
      slow_enable              <= 1'b0;
      ext_pin_is_clock         <= 1'b0;
      rtc_clock_req            <= 1'b0;
      watchdog_domain_clock    <= 1'b0;
      brownout_domain_clock    <= 1'b0;
      main_clock_run           <= 1'b1;
      cpu_clock_en             <= 1'b0;
      peripheral_clock_pin_out <= 1'b0;
      main_clock_status_reg    <= '0;
    end else begin
      fast_enable              <= next_fast_en;
      slow_enable              <= next_slow_en;
      ext_pin_is_clock         <= ext_wanted;
      rtc_clock_req            <= (periph_req.rtc_en || periph_req.pit_en)
                                  && (slow_ok || slow_standby);
      watchdog_domain_clock    <= periph_req.wdt_en && (slow_ok || slow_standby);
      brownout_domain_clock    <= periph_req.bod_sampled && (slow_ok || slow_standby);
      main_clock_run           <= main_wanted;
      cpu_clock_en             <= cpu_tick;
      peripheral_clock_pin_out <= main_tick && div_wrap;
      main_clock_status_reg.source_switch_pending <= active_src != main_source_select;
      main_clock_status_reg.external_clock_stable <= ext_stable;
      main_clock_status_reg.fast_stable           <= fast_ok;
      main_clock_status_reg.slow_stable           <= slow_ok;
    end
  end
endmodule
`default_nettype wire

// ===== pkg/clock_controller_pkg.sv
// clock controller package: source codes, prescaler table, timing counts, carriers
// assumes one 125 MHz system clock; oscillators are modelled as enable/ready pairs
package clock_controller_pkg;
  localparam logic [1:0] SRC_FAST     = 2'h0;  // fast internal oscillator
  localparam logic [1:0] SRC_SLOW     = 2'h1;  // low power slow oscillator
  localparam logic [1:0] SRC_EXT      = 2'h3;  // external clock input
  localparam logic [1:0] RESET_SRC    = SRC_FAST;
  localparam int         PDIV_W       = 4;
  localparam int         NUM_SETTINGS = 12;
  localparam logic [PDIV_W-1:0] RESET_PDIV = 4'h8;  // factor 6
  localparam logic       RESET_PEN    = 1'b1;
  localparam int         UNLOCK_INSTR = 4;        // protected window, in instructions
  localparam int         EXT_START_CYC = 2;       // external pin usable after this
  localparam int         EXT_EDGES    = 8;        // edges taken as proof of stability
  localparam int         CNT_W        = 8;

  typedef enum logic [1:0] {
    MODE_ACTIVE    = 2'h0,
    MODE_IDLE      = 2'h1,
    MODE_STANDBY   = 2'h2,
    MODE_POWERDOWN = 2'h3
  } sleep_mode_t;

  typedef struct packed {
    logic rtc_en;
    logic pit_en;
    logic wdt_en;
    logic bod_sampled;
    logic main_req;  // a peripheral asks for the main clock in standby
    logic ext_req;   // a peripheral asks for the external input
  } periph_req_t;

  typedef struct packed {
    logic external_clock_stable;
    logic slow_stable;
    logic fast_stable;
    logic source_switch_pending;
  } main_clock_status_t;

  // division factor for each of the 11 coded settings; 0 means illegal
  function automatic logic [6:0] pdiv_factor(input logic [PDIV_W-1:0] code);
    unique case (code)
      4'h0: return 7'h02;
      4'h1: return 7'h04;
      4'h2: return 7'h08;
      4'h3: return 7'h10;
      4'h4: return 7'h20;
      4'h5: return 7'h40;
      4'h8: return 7'h06;
      4'h9: return 7'h0A;
      4'hA: return 7'h0C;
      4'hB: return 7'h18;
      4'hC: return 7'h30;
      default: return 7'h00;
    endcase
  endfunction
endpackage

// ===== dv/osc_partner.sv
// oscillator model: ready follows enable after a start-up delay
// assumes enables come from the controller in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module osc_partner #(
  parameter int START = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic fast_enable,
  input  wire logic slow_enable,
  output logic      fast_ready,
  output logic      slow_ready
);
  logic [7:0] fast_cnt;
  logic [7:0] slow_cnt;
  // ready drops at once with enable, so a stopped source never looks stable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt <= 8'h00;
      slow_cnt <= 8'h00;
    end else begin
      fast_cnt <= !fast_enable ? 8'h00 : fast_cnt + 8'(fast_cnt < START);
      slow_cnt <= !slow_enable ? 8'h00 : slow_cnt + 8'(slow_cnt < START);
    end
  end
  assign fast_ready = fast_enable && fast_cnt == 8'(START);
  assign slow_ready = slow_enable && slow_cnt == 8'(START);
endmodule
`default_nettype wire

// ===== dv/main_clock_controller_asserts.sv
// checker for the main clock controller ports
// assumes external edges arrive only after the switch is pending
`timescale 1ns/1ps
`default_nettype none
module main_clock_controller_asserts
  import clock_controller_pkg::*;
#(
  parameter int EDGES_NEEDED = EXT_EDGES
) (
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire sleep_mode_t        sleep_mode,
  input wire periph_req_t        periph_req,
  input wire logic               nvm_busy,
  input wire logic               wr_select,
  input wire logic [1:0]         wdata_select,
  input wire logic               wr_prescaler,
  input wire logic               ext_edge,
  input wire logic               fast_ready,
  input wire logic               fast_enable,
  input wire logic               slow_enable,
  input wire logic               watchdog_domain_clock,
  input wire logic               brownout_domain_clock,
  input wire logic               main_clock_run,
  input wire logic [1:0]         main_source_select,
  input wire logic [PDIV_W-1:0]  prescaler_div,
  input wire logic               prescaler_en,
  input wire main_clock_status_t main_clock_status_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [CNT_W-1:0] edge_cnt;
  wire pend = main_clock_status_reg.source_switch_pending;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) edge_cnt <= '0;
    else edge_cnt <= !pend ? '0 : edge_cnt + CNT_W'(ext_edge);
  end
  sequence s_ext_commit;
    $changed(main_source_select) && main_source_select == SRC_EXT;
  endsequence
  sequence s_wdt_grant;
    ##[1:2] slow_enable ##[0:40] watchdog_domain_clock;
  endsequence
  a_reset_values: assert property ($rose(rst_n) |-> main_source_select == RESET_SRC
    && prescaler_div == RESET_PDIV && prescaler_en == RESET_PEN) else $error("reset values wrong");
  a_select_guard: assert property ($changed(main_source_select) |-> $past(wr_select)
    && $past(wdata_select) == main_source_select) else $error("select changed without write");
  a_pdiv_guard: assert property ($changed(prescaler_div) |-> $past(wr_prescaler))
    else $error("prescaler changed without write");
  a_pending_rise: assert property (s_ext_commit |=> pend) else $error("switch not pending");
  a_refuse_wait: assert property (pend && wr_select |=> $stable(main_source_select))
    else $error("select changed while pending");
  a_edge_count: assert property ($fell(pend) && main_source_select == SRC_EXT |-> edge_cnt >= EDGES_NEEDED)
    else $error("switch before enough edges");
  a_ext_flag: assert property ($fell(pend) && main_source_select == SRC_EXT
    |-> ##[0:2] main_clock_status_reg.external_clock_stable) else $error("external not stable");
  a_clock_stop: assert property ($fell(main_clock_run) |-> !$past(nvm_busy)
    && $past(sleep_mode) inside {MODE_STANDBY, MODE_POWERDOWN}) else $error("main clock stopped early");
  a_wdt_grant: assert property ($rose(periph_req.wdt_en) |-> s_wdt_grant)
    else $error("watchdog clock not granted");
  a_bod_off: assert property ((!periph_req.bod_sampled)[*2] |-> !brownout_domain_clock)
    else $error("brownout clock without request");
  a_fast_status: assert property ((fast_ready && fast_enable)[*2] |-> main_clock_status_reg.fast_stable)
    else $error("fast status low");
endmodule
bind main_clock_controller main_clock_controller_asserts #(.EDGES_NEEDED(EDGES_NEEDED)) main_clock_controller_asserts_inst (
  .clk_sys, .rst_n, .sleep_mode, .periph_req, .nvm_busy, .wr_select, .wdata_select, .wr_prescaler, .ext_edge,
  .fast_ready, .fast_enable, .slow_enable, .watchdog_domain_clock, .brownout_domain_clock, .main_clock_run,
  .main_source_select, .prescaler_div, .prescaler_en, .main_clock_status_reg);
`default_nettype wire

// ===== dv/tb_main_clock_controller.sv
// self-checking bench for the main clock controller
// assumes the oscillator model on the far side; inputs change 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module tb_main_clock_controller
  import clock_controller_pkg::*;
;
  logic clk_sys, rst_n, nvm_busy, key_write, instr_retire, wr_select, wr_prescaler, wdata_pen, wr_standby;
  logic wdata_fast_standby, wdata_slow_standby, fast_ready, slow_ready, ext_edge, fast_enable, slow_enable;
  logic ext_pin_is_clock, rtc_clock_req, watchdog_domain_clock, brownout_domain_clock, main_clock_run;
  logic cpu_clock_en, peripheral_clock_pin_out, prescaler_en;
  logic [1:0] wdata_select, main_source_select;
  logic [PDIV_W-1:0] wdata_pdiv, prescaler_div;
  sleep_mode_t sleep_mode;
  periph_req_t periph_req;
  main_clock_status_t main_clock_status_reg;
  int failures, samples_checked, cycles;
  main_clock_controller #(.EDGES_NEEDED(2)) main_clock_controller_inst (.*);
  osc_partner #(.START(3)) osc_partner_inst (.clk_sys, .rst_n, .fast_enable, .slow_enable, .fast_ready, .slow_ready);
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  task end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    // generous ceiling: the whole sequence needs a few hundred cycles
    if (cycles == 20000) begin
      failures++;
      end_of_test;
    end
  end
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return main_clock_status_reg.source_switch_pending;
      1: return main_clock_run;
      2: return watchdog_domain_clock;
      3: return brownout_domain_clock;
      4: return rtc_clock_req;
      5: return slow_enable;
      6: return fast_enable;
      7: return main_clock_status_reg.external_clock_stable;
      default: return ext_pin_is_clock;
    endcase
  endfunction
  task wait_sig(input int w, input logic v, input string nm);
    int n;
    n = 0;
    while (sig(w) !== v && n < 100) begin
      step;
      n++;
    end
    chk(nm, 8'(v), 8'(sig(w)));
  endtask
  // d packs {pen, pdiv} or select or {slow, fast} standby bits
  task cfg(input bit key, input int instr, input int which, input logic [4:0] d);
    key_write = key;
    step;
    key_write = 0;
    instr_retire = instr > 0;
    repeat (instr) step;
    instr_retire = 0;
    {wdata_pen, wdata_pdiv} = d;
    wdata_select = d[1:0];
    {wdata_slow_standby, wdata_fast_standby} = d[1:0];
    wr_select = which == 0;
    wr_prescaler = which == 1;
    wr_standby = which == 2;
    step;
    {wr_select, wr_prescaler, wr_standby} = 3'h0;
    step;
  endtask
  // counts main ticks between two peripheral ticks
  task per_ratio(input logic [7:0] e);
    int n;
    n = 0;
    while (peripheral_clock_pin_out !== 1'b1 && n < 200) begin
      step;
      n++;
    end
    n = 0;
    step;
    while (n < 200) begin
      n += int'(cpu_clock_en === 1'b1);
      if (peripheral_clock_pin_out === 1'b1) break;
      step;
    end
    chk("ratio", e, 8'(n));
  endtask
  task do_reset;
    rst_n = 0;
    repeat (8) step;
    rst_n = 1;
  endtask
  initial begin
    {nvm_busy, key_write, instr_retire, wr_select, wr_prescaler, wdata_pen, wr_standby, ext_edge} = 8'h00;
    {wdata_fast_standby, wdata_slow_standby, wdata_select, wdata_pdiv} = 8'h00;
    sleep_mode = MODE_ACTIVE;
    periph_req = '0;
    {failures, samples_checked, cycles} = 0;
    rst_n = 0;
    @(posedge clk_sys);
    #1;
    do_reset;
    chk("select", 8'(RESET_SRC), 8'(main_source_select));
    chk("pdiv", 8'h08, 8'(prescaler_div));
    per_ratio(8'h06);
    chk("fast_stable", 8'h01, 8'(main_clock_status_reg.fast_stable));
    $display("test reset done");
    cfg(0, 0, 1, 5'h12);
    chk("pdiv", 8'h08, 8'(prescaler_div));
    cfg(1, 3, 1, 5'h12);
    chk("pdiv", 8'h08, 8'(prescaler_div));
    cfg(1, 2, 1, 5'h12);
    per_ratio(8'h08);
    cfg(1, 0, 1, 5'h05);
    chk("pen", 8'h00, 8'(prescaler_en));
    per_ratio(8'h01);
    $display("test protect done");
    periph_req.wdt_en = 1;
    wait_sig(2, 1, "wdt");
    periph_req.bod_sampled = 1;
    wait_sig(3, 1, "bod");
    periph_req.rtc_en = 1;
    wait_sig(4, 1, "rtc");
    periph_req = '0;
    wait_sig(5, 0, "slow_off");
    sleep_mode = MODE_STANDBY;
    wait_sig(1, 0, "run");
    wait_sig(6, 0, "fast_off");
    periph_req.main_req = 1;
    wait_sig(1, 1, "run");
    periph_req.main_req = 0;
    sleep_mode = MODE_ACTIVE;
    cfg(1, 0, 2, 5'h01);
    sleep_mode = MODE_STANDBY;
    repeat (20) step;
    chk("run", 8'h01, 8'(main_clock_run));
    nvm_busy = 1;
    sleep_mode = MODE_POWERDOWN;
    repeat (20) step;
    chk("run", 8'h01, 8'(main_clock_run));
    nvm_busy = 0;
    wait_sig(1, 0, "run");
    wait_sig(6, 0, "fast_off");
    sleep_mode = MODE_ACTIVE;
    wait_sig(1, 1, "run");
    $display("test sleep done");
    cfg(1, 0, 0, 5'h03);
    chk("select", 8'(SRC_EXT), 8'(main_source_select));
    wait_sig(0, 1, "pending");
    wait_sig(8, 1, "pin");
    cfg(1, 0, 0, 5'h00);
    chk("select", 8'(SRC_EXT), 8'(main_source_select));
    // one edge short of the threshold must leave the switch pending
    ext_edge = 1;
    step;
    ext_edge = 0;
    repeat (3) step;
    chk("pending", 8'h01, 8'(sig(0)));
    ext_edge = 1;
    step;
    ext_edge = 0;
    step;
    wait_sig(0, 0, "pending");
    wait_sig(7, 1, "ext_stable");
    $display("test external done");
    do_reset;
    chk("select", 8'(RESET_SRC), 8'(main_source_select));
    $display("test reset again done");
    end_of_test;
  end
endmodule
`default_nettype wire
